// File: core/rtcev_ctrl.sv
/*
 Interrupt/frequency-output pin control and event-input detector of a real
 time clock. Registers arrive on a byte write/read port at their offsets.
 Assumes the calendar keeps its own counters and supplies an alarm field
 match vector, a time-register write strobe and a time tick; the backup level is derived here from the supply comparators.
*/
// Functional notes
// - Frequency field enables and selects square wave
// - Codes: off, 32768, 4096, 1024, 64, halving
// - Nonzero frequency overrides and disables alarm
// - Pin-off bit silences pin in backup
// - Low-power bit drops trip-level switch condition
// - Alarm runs only with enable set
// - Pulse mode: 250 ms low per match
// - Level mode: low until alarm flag cleared
// - Sample rate: continuous, 2, 1, quarter Hz
// - Debounce: none, 3.9, 15.625, 31.25 ms
// - Event detection only while enabled
// - Halt bit stops counters on event
// - Time write resumes, clears halt bit
// - Halt needs event detection enabled
// - High input sets flag, pulls output low
// - Match sets alarm flag; writes only clear
// - Compare only enabled fields, all equal
// - Event output off in backup if bit
`timescale 1ns/1ps
`default_nettype none
`include "rtcev_params.svh"
module rtcev_ctrl
   import rtcev_pkg::*;
#(
   parameter int CLK_HZ     = `RTCEV_CLK_HZ,
   parameter int OSC_HZ     = `RTCEV_OSC_HZ,
   parameter int FIELDS     = 6
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Register port
   input  wire logic              reg_wr_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   // Status flag clears from the status register
   input  wire logic              alarm_clr_i,
   input  wire logic              event_clr_i,
   // Calendar side
   input  wire logic [FIELDS-1:0] alarm_field_en_i,
   input  wire logic [FIELDS-1:0] alarm_field_eq_i,
   input  wire logic              time_tick_i,
   input  wire logic              time_write_i,
   output logic                   counters_halted_o,
   // Supply comparators
   input  wire logic              vdd_below_bat_i,
   input  wire logic              vdd_below_trip_i,
   output logic                   backup_active_o,
   // Status flags
   output logic                   alarm_status_flag_o,
   output logic                   event_status_flag_o,
   // Pins: open drain, oe low while driving
   input  wire logic              event_input_pin_i,
   output logic                   event_detect_out_o,
   output logic                   event_detect_oe_n_o,
   output logic                   shared_pin_o,
   output logic                   shared_pin_oe_n_o
);
   // ==========================================
   // Registers
   logic [7:0]  irq_output_control;
   logic [7:0]  event_detect_config;
   logic [15:0] osc_acc;
   logic        osc_tick;
   logic [19:0] div_cnt;
   logic [19:0] div_prev;
   logic [13:0] deb_cnt;
   logic [13:0] pulse_cnt;
   logic        pulse_active;
   logic        match_prev;
   rtcev_det_t  det_state;

   // Named field views
   wire [3:0] square_wave_select    = irq_output_control[3:0];
   wire       pin_off_in_battery    = irq_output_control[`RTCEV_PIN_OFF_BAT_BIT];
   wire       low_power_switch_mode = irq_output_control[`RTCEV_LP_MODE_BIT];
   wire       alarm_enable_bit      = irq_output_control[`RTCEV_ALARM_EN_BIT];
   wire       alarm_pulse_mode      = irq_output_control[`RTCEV_PULSE_MODE_BIT];
   wire [1:0] event_sample_rate     = event_detect_config[1:0];
   wire [1:0] event_debounce_time   = event_detect_config[3:2];
   wire       event_enable          = event_detect_config[`RTCEV_EVENT_EN_BIT];
   wire       halt_on_event         = event_detect_config[`RTCEV_HALT_BIT];
   wire       event_out_off_in_batt = event_detect_config[`RTCEV_EVOUT_OFF_BIT];

   // ==========================================
   // Functions
   // Divider bit whose toggle gives the selected wave; 32768 Hz is the tick itself
   function automatic logic [4:0] wave_bit(input logic [3:0] sel);
      logic [4:0] b;
      b = 5'd0;
      unique case (sel)
         4'h2:    b = 5'd2;    // 4096 Hz
         4'h3:    b = 5'd4;    // 1024 Hz
         default: b = 5'(sel) + 5'd4; // 64 Hz at 4, halving up to 1/32 Hz
      endcase
      return b;
   endfunction

   function automatic logic [13:0] deb_ticks(input logic [1:0] sel);
      logic [13:0] t;
      t = 14'h0000;
      unique case (sel)
         2'b00: t = 14'h0000;
         2'b01: t = 14'(`RTCEV_DEB1_TICKS);
         2'b10: t = 14'(`RTCEV_DEB2_TICKS);
         2'b11: t = 14'(`RTCEV_DEB3_TICKS);
      endcase
      return t;
   endfunction

   // ==========================================
   // Oscillator time base: fractional accumulator, 32768 ticks per second
   wire [31:0] acc_sum = 32'(osc_acc) + 32'(OSC_HZ / 4096);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_acc  <= 16'h0000;
         osc_tick <= 1'b0;
      end else if (acc_sum >= 32'(CLK_HZ / 4096)) begin
         osc_acc  <= 16'(acc_sum - 32'(CLK_HZ / 4096));
         osc_tick <= 1'b1;
      end else begin
         osc_acc  <= 16'(acc_sum);
         osc_tick <= 1'b0;
      end
   end

   // Ripple divider of the tick; bit n toggles at 16384/2^n Hz
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt  <= 20'h0_0000;
         div_prev <= 20'h0_0000;
      end else if (osc_tick) begin
         div_cnt  <= div_cnt + 20'h0_0001;
         div_prev <= div_cnt;
      end
   end

   // ==========================================
   // Register writes and automatic halt clear
   wire wr_irq = reg_wr_i && (reg_addr_i == `RTCEV_IRQ_CTRL_OFS);
   wire wr_event = reg_wr_i && (reg_addr_i == `RTCEV_EVENT_CFG_OFS);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_output_control  <= `RTCEV_IRQ_CTRL_RST;
         event_detect_config <= `RTCEV_EVENT_CFG_RST;
      end else begin
         if (wr_irq)
            irq_output_control <= reg_wdata_i;
         if (wr_event)
            event_detect_config <= reg_wdata_i;
         else if (time_write_i && counters_halted_o)
            event_detect_config[`RTCEV_HALT_BIT] <= 1'b0;
      end
   end

   // Read mux, registered
   wire [7:0] next_rdata = (reg_addr_i == `RTCEV_IRQ_CTRL_OFS) ? irq_output_control :
                           (reg_addr_i == `RTCEV_EVENT_CFG_OFS) ? event_detect_config :
                           8'h00;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else
         reg_rdata_o <= next_rdata;
   end

   // ==========================================
   // Supply switch decision
   wire next_backup = low_power_switch_mode ? vdd_below_bat_i
                                            : (vdd_below_bat_i && vdd_below_trip_i);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         backup_active_o <= 1'b0;
      else
         backup_active_o <= next_backup;
   end

   // ==========================================
   // Alarm match and flag
   wire wave_on     = (square_wave_select != 4'h0);
   wire alarm_live  = alarm_enable_bit && !wave_on;
   wire any_field   = |alarm_field_en_i;
   wire match_now   = any_field &&
                      ((alarm_field_eq_i | ~alarm_field_en_i) == '1);
   // Edge of the match so one time slot gives one alarm
   wire alarm_hit   = alarm_live && match_now && !match_prev;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         match_prev          <= 1'b0;
         alarm_status_flag_o <= 1'b0;
      end else begin
         match_prev <= match_now;
         // Set wins over a clear in the same cycle; writes never set
         if (alarm_hit)
            alarm_status_flag_o <= 1'b1;
         else if (alarm_clr_i)
            alarm_status_flag_o <= 1'b0;
      end
   end

   // 250 ms low pulse, retriggered by each match
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_active <= 1'b0;
         pulse_cnt    <= 14'h0000;
      end else if (alarm_hit && alarm_pulse_mode) begin
         pulse_active <= 1'b1;
         pulse_cnt    <= 14'(`RTCEV_ALARM_PULSE_TICKS - 1);
      end else if (pulse_active && osc_tick) begin
         if (pulse_cnt == 14'h0000)
            pulse_active <= 1'b0;
         else
            pulse_cnt <= pulse_cnt - 14'h0001;
      end
   end

   // ==========================================
   // Shared pin: wave has priority, then alarm
   wire [4:0] wsel      = wave_bit(square_wave_select);
   wire       wave_lvl  = (square_wave_select == 4'h1) ? osc_tick : div_cnt[wsel];
   wire       alarm_low = alarm_live &&
                          (alarm_pulse_mode ? pulse_active : alarm_status_flag_o);
   wire       pin_off   = pin_off_in_battery && backup_active_o;
   // A high wave level releases the open-drain pin
   wire       next_pin_oe_n = pin_off ? 1'b1 :
                              wave_on ? wave_lvl :
                              !alarm_low;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shared_pin_o      <= 1'b0;
         shared_pin_oe_n_o <= 1'b1;
      end else begin
         shared_pin_o      <= 1'b0;
         shared_pin_oe_n_o <= next_pin_oe_n;
      end
   end

   // ==========================================
   // Event sampling strobe; 2 Hz, 1 Hz, 1/4 Hz from divider rollovers
   wire rise14 = div_cnt[14] && !div_prev[14];
   wire rise15 = div_cnt[15] && !div_prev[15];
   wire rise16 = div_cnt[16] && !div_prev[16];
   wire sample_now = (event_sample_rate == 2'b00) ? 1'b1 :
                     (event_sample_rate == 2'b01) ? (osc_tick && (div_cnt[13:0] == '1)) :
                     (event_sample_rate == 2'b10) ? (osc_tick && rise14) :
                     (osc_tick && rise16 && !rise15);
   // Debounce only in sampled mode; software must not pair it with continuous
   wire [13:0] deb_len = (event_sample_rate == 2'b00) ? 14'h0000 :
                         deb_ticks(event_debounce_time);

   // Detector: idle, filtering, held until flag clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         det_state           <= RTCEV_IDLE;
         deb_cnt             <= 14'h0000;
         event_status_flag_o <= 1'b0;
      end else if (!event_enable) begin
         det_state <= RTCEV_IDLE;
         if (event_clr_i)
            event_status_flag_o <= 1'b0;
      end else begin
         unique case (det_state)
            RTCEV_IDLE: begin
               if (sample_now && event_input_pin_i) begin
                  if (deb_len == 14'h0000) begin
                     det_state           <= RTCEV_HELD;
                     event_status_flag_o <= 1'b1;
                  end else begin
                     det_state <= RTCEV_FILTER;
                     deb_cnt   <= deb_len;
                  end
               end else if (event_clr_i)
                  event_status_flag_o <= 1'b0;
            end
            RTCEV_FILTER: begin
               if (!event_input_pin_i)
                  det_state <= RTCEV_IDLE;
               else if (osc_tick && deb_cnt == 14'h0001) begin
                  det_state           <= RTCEV_HELD;
                  event_status_flag_o <= 1'b1;
               end else if (osc_tick)
                  deb_cnt <= deb_cnt - 14'h0001;
               if (event_clr_i && !(event_input_pin_i && osc_tick && deb_cnt == 14'h0001))
                  event_status_flag_o <= 1'b0;
            end
            RTCEV_HELD: begin
               // A fresh event in the clear cycle wins over the clear
               if (event_clr_i && !(sample_now && event_input_pin_i && deb_len == 14'h0000)) begin
                  event_status_flag_o <= 1'b0;
                  det_state           <= RTCEV_IDLE;
               end
            end
            default: det_state <= RTCEV_IDLE;
         endcase
      end
   end

   // Event output and counter halt
   wire event_hit = event_enable && (det_state != RTCEV_HELD) && event_status_flag_o == 1'b0 &&
                    ((det_state == RTCEV_IDLE && sample_now && event_input_pin_i &&
                      deb_len == 14'h0000) ||
                     (det_state == RTCEV_FILTER && event_input_pin_i && osc_tick &&
                      deb_cnt == 14'h0001));
   wire evout_off = event_out_off_in_batt && backup_active_o;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_detect_out_o  <= 1'b0;
         event_detect_oe_n_o <= 1'b1;
         counters_halted_o   <= 1'b0;
      end else begin
         event_detect_out_o  <= 1'b0;
         event_detect_oe_n_o <= !(event_status_flag_o && !evout_off);
         if (event_hit && halt_on_event && event_enable)
            counters_halted_o <= 1'b1;
         else if (time_write_i)
            counters_halted_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: include/rtcev_params.svh
/*
 Constants for the interrupt/frequency-output and event-detect control block.
 Assumes a 200 MHz core clock; timing is derived from a 32.768 kHz tick built here.
*/
`ifndef RTCEV_PARAMS_SVH
`define RTCEV_PARAMS_SVH
// ==========================================
// Register offsets
`define RTCEV_IRQ_CTRL_OFS     8'h08
`define RTCEV_EVENT_CFG_OFS    8'h09
// ==========================================
// Field positions, irq_output_control
`define RTCEV_PULSE_MODE_BIT   7
`define RTCEV_ALARM_EN_BIT     6
`define RTCEV_LP_MODE_BIT      5
`define RTCEV_PIN_OFF_BAT_BIT  4
// Field positions, event_detect_config
`define RTCEV_EVOUT_OFF_BIT    6
`define RTCEV_HALT_BIT         5
`define RTCEV_EVENT_EN_BIT     4
// ==========================================
// Reset values
`define RTCEV_IRQ_CTRL_RST     8'h00
`define RTCEV_EVENT_CFG_RST    8'h00
// ==========================================
// Timing
`define RTCEV_CLK_HZ           200000000
`define RTCEV_OSC_HZ           32768
`define RTCEV_ALARM_PULSE_MS   250
// Pulse width in oscillator ticks
`define RTCEV_ALARM_PULSE_TICKS (`RTCEV_OSC_HZ * `RTCEV_ALARM_PULSE_MS / 1000)
// Debounce times in oscillator ticks: 3.9 ms, 15.625 ms, 31.25 ms
`define RTCEV_DEB1_TICKS       128
`define RTCEV_DEB2_TICKS       512
`define RTCEV_DEB3_TICKS       1024
`endif

// File: include/rtcev_pkg.sv
/*
 Types for the interrupt/frequency-output and event-detect control block.
 Assumes nothing beyond the params header.
*/
package rtcev_pkg;
   // ==========================================
   // Event detector states, Gray along the path
   typedef enum logic [1:0] {
      RTCEV_IDLE   = 2'b00,
      RTCEV_FILTER = 2'b01,
      RTCEV_HELD   = 2'b11
   } rtcev_det_t;
endpackage

// File: bench/rtcev_props.sv
/* Checker for rtcev_ctrl: alarm pin, flags, supply switch, event output.
   Assumes a bind to the top ports; it shadows both config registers. */
`timescale 1ns/1ps
`default_nettype none
module rtcev_props #(
   parameter int FIELDS = 6
) (
   // Clock, reset and register writes
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic              reg_wr_i,
   input wire logic [7:0]        reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   // Calendar, supplies and clears
   input wire logic              alarm_clr_i,
   input wire logic              time_write_i,
   input wire logic [FIELDS-1:0] alarm_field_en_i,
   input wire logic [FIELDS-1:0] alarm_field_eq_i,
   input wire logic              vdd_below_bat_i,
   input wire logic              vdd_below_trip_i,
   input wire logic              event_input_pin_i,
   // Observed outputs
   input wire logic              backup_active_o,
   input wire logic              counters_halted_o,
   input wire logic              alarm_status_flag_o,
   input wire logic              event_status_flag_o,
   input wire logic              event_detect_oe_n_o,
   input wire logic              shared_pin_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] irq_cfg;
   logic [7:0] event_cfg;
   // ==========================================
   // Shadows; the halt bit drops as the design's does on a resume
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_cfg   <= 8'h00;
         event_cfg <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == 8'h08) begin
         irq_cfg <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == 8'h09) begin
         event_cfg <= reg_wdata_i;
      end else if (time_write_i && counters_halted_o) begin
         event_cfg[5] <= 1'b0;
      end
   end
   // Derived conditions
   wire fz    = irq_cfg[3:0] == 4'h0;
   wire al_on = irq_cfg[6] && fz;
   wire sil   = irq_cfg[4] && backup_active_o;
   wire sw    = vdd_below_bat_i && (irq_cfg[5] || vdd_below_trip_i);
   wire match = |alarm_field_en_i && ((alarm_field_eq_i & alarm_field_en_i) == alarm_field_en_i);
   // ==========================================
   // Properties
   a_flag_walk: assert property ($rose(match) && al_on |=> alarm_status_flag_o)
      else $error("alarm flag missing after match");
   a_alarm_gate: assert property ($rose(alarm_status_flag_o) |-> $past(al_on && match))
      else $error("alarm flag set while alarm off");
   a_flag_clear: assert property ($fell(alarm_status_flag_o) |-> $past(alarm_clr_i))
      else $error("alarm flag fell without clear");
   a_level_pin: assert property (
      (alarm_status_flag_o && al_on && !irq_cfg[7] && !sil)[*2] |-> !shared_pin_oe_n_o)
      else $error("level alarm not on pin");
   a_pin_idle: assert property ((fz && !irq_cfg[7] && !alarm_status_flag_o)[*2]
      |-> shared_pin_oe_n_o)
      else $error("pin driven while idle");
   a_pin_silenced: assert property (sil [*2] |-> shared_pin_oe_n_o)
      else $error("pin driven in backup");
   a_backup_sel: assert property (1'b1 |=> backup_active_o == $past(sw))
      else $error("supply switch wrong");
   a_event_walk: assert property (
      event_cfg[4] && event_cfg[1:0] == 2'b00 && event_input_pin_i |=> event_status_flag_o)
      else $error("event not flagged");
   a_event_gate: assert property ($rose(event_status_flag_o) |-> $past(event_cfg[4]))
      else $error("event flagged while disabled");
   a_halt_stop: assert property (
      $rose(event_status_flag_o) && $past(event_cfg[5]) |-> counters_halted_o)
      else $error("counters not halted");
   a_evout_off: assert property (
      (event_cfg[6] && backup_active_o)[*2] |-> event_detect_oe_n_o)
      else $error("event output driven in backup");
   c_alarm: cover property ($rose(alarm_status_flag_o));
   c_event: cover property ($rose(event_status_flag_o));
   c_halt: cover property ($rose(counters_halted_o));
endmodule
`default_nettype wire

// File: bench/rtcev_switch.sv
/* Far side model: event switch and calendar field comparators.
   Assumes the bench commands it; disabled fields compare equal only while match_i is low. */
`timescale 1ns/1ps
`default_nettype none
module rtcev_switch (
   // Commands
   input  wire logic       press_i,
   input  wire logic       match_i,
   input  wire logic [5:0] field_en_i,
   // Toward the block
   output logic            event_input_pin_o,
   output logic [5:0]      field_eq_o
);
   // Closed switch reads high; enabled fields follow match_i, unused ones read its inverse
   assign event_input_pin_o = press_i;
   assign field_eq_o        = match_i ? field_en_i : ~field_en_i;
endmodule
`default_nettype wire

// File: bench/rtcev_ctrl_tb.sv
/* Bench for rtcev_ctrl: registers, alarm pin, supply and event detector.
   Assumes the switch model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rtcev_ctrl_tb;
   logic       clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, twr = 1'b0;
   logic       clr_a = 1'b0, clr_e = 1'b0, bat = 1'b0, trip = 1'b0;
   logic       press = 1'b0, match = 1'b0, evp, bk, halted, aflag, eflag, evd_oe_n, pin_oe_n;
   logic       pin_d, evd_d;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [5:0] f_en = 6'h03, f_eq;
   int         checks = 0, miscompares = 0, cyc = 0;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   // ==========================================
   // Design and far side
   rtcev_ctrl #(.FIELDS(6)) u_rtcev_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .alarm_clr_i(clr_a),
      .event_clr_i(clr_e), .alarm_field_en_i(f_en), .alarm_field_eq_i(f_eq),
      .time_tick_i(1'b0), .time_write_i(twr), .counters_halted_o(halted),
      .vdd_below_bat_i(bat), .vdd_below_trip_i(trip), .backup_active_o(bk),
      .alarm_status_flag_o(aflag), .event_status_flag_o(eflag), .event_input_pin_i(evp),
      .event_detect_out_o(evd_d), .event_detect_oe_n_o(evd_oe_n), .shared_pin_o(pin_d),
      .shared_pin_oe_n_o(pin_oe_n));
   rtcev_switch u_rtcev_switch (.press_i(press), .match_i(match), .field_en_i(f_en),
      .event_input_pin_o(evp), .field_eq_o(f_eq));
   // ==========================================
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      addr = a;
      wait_n(2);
      chk(rdata, exp);
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      rd_reg(8'h08, 8'h00);
      wr_reg(8'h08, 8'h2f);
      rd_reg(8'h08, 8'h2f);
      wr_reg(8'h0a, 8'hff);
      rd_reg(8'h0a, 8'h00);
      wr_reg(8'h08, 8'h00);
   endtask
   task automatic t_level;
      wr_reg(8'h08, 8'h40);
      match = 1'b1;
      wait_n(3);
      match = 1'b0;
      wait_n(3);
      chk({6'h0, aflag, pin_oe_n}, 8'h02);
      clr_a = 1'b1;
      wait_n(1);
      clr_a = 1'b0;
      wait_n(3);
      chk({6'h0, aflag, pin_oe_n}, 8'h01);
   endtask
   task automatic t_wave;
      int lows;
      lows = 0;
      wr_reg(8'h08, 8'h41);
      match = 1'b1;
      wait_n(3);
      match = 1'b0;
      chk({7'h0, aflag}, 8'h00);
      // One period of the fastest wave is about 6104 cycles
      repeat (7000) begin
         @(negedge clk_i);
         lows += (pin_oe_n === 1'b0);
      end
      chk({7'h0, lows > 0 && lows < 7000}, 8'h01);
      wr_reg(8'h08, 8'h00);
   endtask
   task automatic t_event;
      wr_reg(8'h09, 8'h30); // Continuous, no debounce
      press = 1'b1;
      wait_n(3);
      chk({5'h0, eflag, halted, evd_oe_n}, 8'h06);
      press = 1'b0;
      twr = 1'b1;
      wait_n(1);
      twr = 1'b0;
      wait_n(2);
      chk({7'h0, halted}, 8'h00);
      rd_reg(8'h09, 8'h10);
      clr_e = 1'b1;
      wait_n(1);
      clr_e = 1'b0;
      wait_n(2);
      chk({6'h0, eflag, evd_oe_n}, 8'h01);
      wr_reg(8'h09, 8'h20);
      press = 1'b1;
      wait_n(3);
      chk({6'h0, eflag, halted}, 8'h00);
      // Sampled at 2 Hz the held input waits for the next strobe
      wr_reg(8'h09, 8'h11);
      wait_n(3);
      chk({7'h0, eflag}, 8'h00);
      press = 1'b0;
   endtask
   task automatic t_supply;
      bat = 1'b1;
      wait_n(3);
      chk({7'h0, bk}, 8'h00);
      wr_reg(8'h08, 8'h20);
      wait_n(2);
      chk({7'h0, bk}, 8'h01);
      trip = 1'b1;
      wr_reg(8'h08, 8'hd0);
      wr_reg(8'h09, 8'h50);
      match = 1'b1;
      press = 1'b1;
      wait_n(3);
      chk({4'h0, bk, aflag, pin_oe_n, evd_oe_n}, 8'h0f);
      bat = 1'b0;
      clr_a = 1'b1;
      wait_n(1);
      clr_a = 1'b0;
      wait_n(20);
      // Pulse mode keeps the pin low after the flag is cleared
      chk({5'h0, aflag, pin_oe_n, evd_oe_n}, 8'h00);
      // Open-drain data lines stay low while pulling
      chk({6'h0, pin_d, evd_d}, 8'h00);
   endtask
   // ==========================================
   // Cycle ceiling; the run needs about 7100 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         give_verdict;
      end
   end
   // Main sequence
   initial begin
      wait_n(5);
      rst_n_i = 1'b1;
      t_regs;
      t_level;
      t_wave;
      t_event;
      t_supply;
      give_verdict;
   end
endmodule
bind rtcev_ctrl rtcev_props #(.FIELDS(FIELDS)) u_rtcev_props (.clk_i, .rst_n_i, .reg_wr_i,
   .reg_addr_i, .reg_wdata_i, .alarm_clr_i, .time_write_i, .alarm_field_en_i,
   .alarm_field_eq_i, .vdd_below_bat_i, .vdd_below_trip_i, .event_input_pin_i,
   .backup_active_o, .counters_halted_o, .alarm_status_flag_o, .event_status_flag_o,
   .event_detect_oe_n_o, .shared_pin_oe_n_o);
`default_nettype wire
